// ### logic/scb_pkg.sv
package scb_pkg;

	// ---------------------------------------------------------------
	// Fixed locations.
	// ---------------------------------------------------------------
	localparam logic [31:0] MODULE_BASE_ADDR = 32'h0003FF00;
	localparam logic [3:0] FC_CPU_SPACE = 4'h7;
	localparam logic [3:0] FC_SUPER_DATA = 4'h5;
	localparam logic [11:0] OFS_SYS_CONFIG = 12'h000;
	localparam logic [11:0] OFS_AUTOVECTOR_RESPONSE_RESET = 12'h006;
	localparam int BASE_FIELD_LSB = 12;

	// ---------------------------------------------------------------
	// Module base register layout.
	// ---------------------------------------------------------------
	localparam int MB_VALID_POS = 0;
	localparam int MB_SPACE_LSB = 1;
	localparam int MB_SPACE_MSB = 9;
	localparam int SPACE_DMA_IDX = 8;
	localparam logic [31:0] MODULE_BASE_RESET = 32'h00000000;
	localparam logic [31:0] MODULE_BASE_WMASK = 32'hFFFFF3FF;

	// ---------------------------------------------------------------
	// System configuration register layout.
	// ---------------------------------------------------------------
	localparam int CFG_FREEZE_TIMERS_POS = 14;
	localparam int CFG_FREEZE_BUSMON_POS = 13;
	localparam int CFG_AUTOVECTOR_POS = 12;
	localparam int CFG_SHOW_MSB = 9;
	localparam int CFG_SHOW_LSB = 8;
	localparam int CFG_SUPER_LOCK_POS = 7;
	localparam int CFG_ARB_MSB = 3;
	localparam logic [15:0] SYS_CONFIG_RESET = 16'h000F;
	localparam logic [15:0] SYS_CONFIG_WMASK = 16'h738F;

	// ---------------------------------------------------------------
	// Autovector mask and reset cause layout.
	// ---------------------------------------------------------------
	localparam logic [7:0] AUTOVECTOR_RESPONSE_MASK_RESET = 8'h00;
	localparam logic [7:0] CAUSE_PIN = 8'h80;
	localparam logic [7:0] CAUSE_SUPPLY = 8'h40;
	localparam logic [7:0] CAUSE_WATCHDOG = 8'h20;
	localparam logic [7:0] CAUSE_DFAULT = 8'h10;
	localparam logic [7:0] CAUSE_REF_MISSING = 8'h04;
	localparam logic [7:0] CAUSE_INSTR = 8'h02;
	localparam logic [7:0] CAUSE_NONE = 8'h00;

	// ---------------------------------------------------------------
	// Bus access states.
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SCB_IDLE,
		SCB_ANSWER
	} scb_state_t;

endpackage

// ### logic/scb_sys_config.sv
`timescale 1ns/100ps
// Function
// - Block base is the upper 20 bits of module base, 4 KB aligned.
// - A set space mask bit sends that space's block accesses external.
// - Mask bits map: 8 DMA, 7 CPU, 6/5 supervisor, 2/1 user, 4/3/0 reserved.
// - Block registers are unreachable until the base valid bit is set.
// - Module base sits in CPU space at fixed address, never run externally.
// - Freeze with freeze-timers bit halts watchdog and periodic timer.
// - Freeze with freeze-bus-monitor bit disables the bus monitor.
// - A configuration bit enables the automatic vector response.
// - Show select: 00 arbitration only, 01 show only, 1x both.
// - Show cycles drive address, data, control; data strobe times address.
// - Without show cycles no data or strobes go out for internal accesses.
// - External requests ignored while arbitration off; masters wait meanwhile.
// - Supervisor lock: user writes to shared registers ignored with bus fault.
// - Arbitration priority resets to F; software sets unique F..1.
// - Priority zero: no arbitration, all interrupts discarded.
// - Autovector for masked external level only with nonzero priority.
// - Reset cause loads on leaving reset, one bit set, read-only.
// - Cause flags: pin, supply, watchdog, double fault, clock loss.
// - Clock-loss reset only with its enable set and VCO running.
// - Instruction reset sets its own flag and keeps configuration.
module scb_sys_config (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_bus_req,
	input wire logic i_bus_wr,
	input wire logic [31:0] i_bus_addr,
	input wire logic [3:0] i_func_code,
	input wire logic [31:0] i_bus_wdata,
	input wire logic i_shared_reg_sel,
	input wire logic i_freeze,
	input wire logic i_ext_bus_req,
	input wire logic i_int_ack_cycle,
	input wire logic [2:0] i_int_ack_level,
	input wire logic i_cause_pin,
	input wire logic i_cause_supply,
	input wire logic i_cause_watchdog,
	input wire logic i_cause_dfault,
	input wire logic i_cause_instr,
	input wire logic i_clock_lost,
	input wire logic i_clock_loss_reset_enable,
	input wire logic i_vco_enable,
	output logic o_bus_ack,
	output logic [31:0] o_bus_rdata,
	output logic o_bus_fault_resp,
	output logic o_run_external,
	output logic o_periph_sel,
	output logic o_show_drive,
	output logic o_addr_strobe_n,
	output logic o_data_strobe_n,
	output logic [31:0] o_show_addr,
	output logic [31:0] o_show_data,
	output logic o_ext_arb_enable,
	output logic o_ext_req_accepted,
	output logic o_timers_halt,
	output logic o_busmon_disable,
	output logic o_arb_participate,
	output logic [3:0] o_int_arb_priority,
	output logic o_int_discard,
	output logic o_autovector_response,
	output logic o_ref_missing_reset_req
);

	// ---------------------------------------------------------------
	// Register state.
	// ---------------------------------------------------------------
	logic [31:0] module_base_reg;
	logic [15:0] sys_config_reg;
	logic [7:0] autovector_mask_reg;
	logic [7:0] reset_cause_reg;
	logic [7:0] cause_hold_reg;
	logic rst_seen_reg;
	scb_pkg::scb_state_t state_reg;

	logic [19:0] base_addr_field;
	logic [8:0] space_mask_bits;
	logic base_valid;
	logic [3:0] space_idx;
	logic space_masked;
	logic base_hit;
	logic block_hit;
	logic [11:0] block_ofs;
	logic own_reg;
	logic is_user;
	logic freeze_timers_bit;
	logic freeze_busmon_bit;
	logic autovector_en;
	logic [1:0] show_cycle_select;
	logic supervisor_lock_bit;
	logic [3:0] int_arb_priority;
	logic show_en;
	logic show_now;
	logic fault_now;
	logic ref_missing_ok;
	logic [7:0] cause_now;
	logic [31:0] rdata_next;

	// Field views of the stored registers.
	assign base_addr_field = module_base_reg[31:scb_pkg::BASE_FIELD_LSB];
	assign space_mask_bits = module_base_reg[scb_pkg::MB_SPACE_MSB:scb_pkg::MB_SPACE_LSB];
	assign base_valid = module_base_reg[scb_pkg::MB_VALID_POS];
	assign freeze_timers_bit = sys_config_reg[scb_pkg::CFG_FREEZE_TIMERS_POS];
	assign freeze_busmon_bit = sys_config_reg[scb_pkg::CFG_FREEZE_BUSMON_POS];
	assign autovector_en = sys_config_reg[scb_pkg::CFG_AUTOVECTOR_POS];
	assign show_cycle_select = sys_config_reg[scb_pkg::CFG_SHOW_MSB:scb_pkg::CFG_SHOW_LSB];
	assign supervisor_lock_bit = sys_config_reg[scb_pkg::CFG_SUPER_LOCK_POS];
	assign int_arb_priority = sys_config_reg[scb_pkg::CFG_ARB_MSB:0];

	// ---------------------------------------------------------------
	// Address decode.
	// ---------------------------------------------------------------
	// Any DMA code lands on one mask bit; the others index by their low bits.
	assign space_idx = i_func_code[3] ? 4'(scb_pkg::SPACE_DMA_IDX) : {1'b0, i_func_code[2:0]};
	assign space_masked = space_mask_bits[space_idx];
	assign base_hit = (i_func_code == scb_pkg::FC_CPU_SPACE)
		&& (i_bus_addr == scb_pkg::MODULE_BASE_ADDR);
	assign block_hit = base_valid && !space_masked && !base_hit
		&& (i_bus_addr[31:scb_pkg::BASE_FIELD_LSB] == base_addr_field);
	assign block_ofs = i_bus_addr[11:0];
	assign own_reg = (block_ofs == scb_pkg::OFS_SYS_CONFIG)
		|| (block_ofs == scb_pkg::OFS_AUTOVECTOR_RESPONSE_RESET);
	assign is_user = !i_func_code[2];
	// Own registers are supervisor only; shared ones refuse user writes only while the lock is set.
	assign fault_now = i_bus_req && block_hit && is_user
		&& ((own_reg) || (i_shared_reg_sel && supervisor_lock_bit && i_bus_wr));

	// Read data for the answer cycle; narrow registers sit in the low half.
	always_comb begin
		rdata_next = 32'h00000000;
		if (base_hit) begin
			rdata_next = module_base_reg;
		end else if (block_hit && block_ofs == scb_pkg::OFS_SYS_CONFIG) begin
			rdata_next = {16'h0000, sys_config_reg};
		end else if (block_hit && block_ofs == scb_pkg::OFS_AUTOVECTOR_RESPONSE_RESET) begin
			rdata_next = {16'h0000, autovector_mask_reg, reset_cause_reg};
		end
	end

	// ---------------------------------------------------------------
	// Bus answer, one cycle after the request.
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_reg <= scb_pkg::SCB_IDLE;
			o_bus_ack <= 1'b0;
			o_bus_rdata <= 32'h00000000;
			o_bus_fault_resp <= 1'b0;
			o_run_external <= 1'b0;
			o_periph_sel <= 1'b0;
		end else begin
			case (state_reg)
				scb_pkg::SCB_IDLE: begin
					o_bus_ack <= i_bus_req;
					o_bus_rdata <= (i_bus_req && !i_bus_wr && !fault_now) ? rdata_next : 32'h00000000;
					o_bus_fault_resp <= fault_now;
					o_run_external <= i_bus_req && !base_hit && !block_hit;
					o_periph_sel <= i_bus_req && block_hit && !own_reg && !fault_now;
					if (i_bus_req) begin
						state_reg <= scb_pkg::SCB_ANSWER;
					end
				end
				scb_pkg::SCB_ANSWER: begin
					// The answer stands for exactly one cycle.
					o_bus_ack <= 1'b0;
					o_bus_fault_resp <= 1'b0;
					o_run_external <= 1'b0;
					o_periph_sel <= 1'b0;
					state_reg <= scb_pkg::SCB_IDLE;
				end
				default: begin
					state_reg <= scb_pkg::SCB_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Writable registers.
	// ---------------------------------------------------------------
	// An instruction reset leaves the configuration as software left it.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			if (!i_cause_instr) begin
				module_base_reg <= scb_pkg::MODULE_BASE_RESET;
				sys_config_reg <= scb_pkg::SYS_CONFIG_RESET;
				autovector_mask_reg <= scb_pkg::AUTOVECTOR_RESPONSE_MASK_RESET;
			end
		end else if (i_bus_req && i_bus_wr && state_reg == scb_pkg::SCB_IDLE) begin
			if (base_hit) begin
				module_base_reg <= i_bus_wdata & scb_pkg::MODULE_BASE_WMASK;
			end else if (block_hit && !fault_now) begin
				if (block_ofs == scb_pkg::OFS_SYS_CONFIG) begin
					sys_config_reg <= i_bus_wdata[15:0] & scb_pkg::SYS_CONFIG_WMASK;
				end else if (block_ofs == scb_pkg::OFS_AUTOVECTOR_RESPONSE_RESET) begin
					// Only the mask byte takes the write; the cause byte is read-only.
					autovector_mask_reg <= i_bus_wdata[15:8];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Reset cause capture.
	// ---------------------------------------------------------------
	assign ref_missing_ok = i_clock_lost && i_clock_loss_reset_enable && i_vco_enable;
	assign o_ref_missing_reset_req = ref_missing_ok;

	// One source wins by fixed priority so exactly one flag is ever set.
	always_comb begin
		if (i_cause_supply) begin
			cause_now = scb_pkg::CAUSE_SUPPLY;
		end else if (i_cause_pin) begin
			cause_now = scb_pkg::CAUSE_PIN;
		end else if (i_cause_watchdog) begin
			cause_now = scb_pkg::CAUSE_WATCHDOG;
		end else if (i_cause_dfault) begin
			cause_now = scb_pkg::CAUSE_DFAULT;
		end else if (ref_missing_ok) begin
			cause_now = scb_pkg::CAUSE_REF_MISSING;
		end else if (i_cause_instr) begin
			cause_now = scb_pkg::CAUSE_INSTR;
		end else begin
			cause_now = scb_pkg::CAUSE_NONE;
		end
	end

	// Causes are held while reset is asserted and published at its release.
	// Only a caught cause inside a running reset is kept, so the power-on
	// contents of the holding flags can never block the first capture.
	always_ff @(posedge i_sys_clk) begin
		rst_seen_reg <= i_rst;
		if (i_rst) begin
			if (rst_seen_reg && cause_hold_reg != scb_pkg::CAUSE_NONE) begin
				cause_hold_reg <= cause_hold_reg;
			end else begin
				cause_hold_reg <= cause_now;
			end
		end else if (rst_seen_reg) begin
			reset_cause_reg <= (cause_hold_reg == scb_pkg::CAUSE_NONE)
				? scb_pkg::CAUSE_PIN : cause_hold_reg;
		end
	end

	// ---------------------------------------------------------------
	// Show cycles and external arbitration.
	// ---------------------------------------------------------------
	assign show_en = (show_cycle_select != 2'b00);
	assign o_ext_arb_enable = (show_cycle_select != 2'b01);
	assign o_ext_req_accepted = i_ext_bus_req && o_ext_arb_enable;
	// A request in the answer cycle is refused, so it must not be shown either.
	assign show_now = show_en && i_bus_req && (block_hit || base_hit)
		&& (state_reg == scb_pkg::SCB_IDLE);

	// The show copy trails the access by one cycle, so data is stable
	// well before the falling edge that follows the strobe release.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_show_drive <= 1'b0;
			o_data_strobe_n <= 1'b1;
			o_show_addr <= 32'h00000000;
			o_show_data <= 32'h00000000;
		end else begin
			o_show_drive <= show_now;
			o_data_strobe_n <= !show_now;
			if (show_now) begin
				o_show_addr <= i_bus_addr;
				o_show_data <= i_bus_wr ? i_bus_wdata : rdata_next;
			end
		end
	end
	assign o_addr_strobe_n = 1'b1;

	// ---------------------------------------------------------------
	// Freeze, interrupt arbitration and autovector.
	// ---------------------------------------------------------------
	assign o_timers_halt = i_freeze && freeze_timers_bit;
	assign o_busmon_disable = i_freeze && freeze_busmon_bit;
	assign o_int_arb_priority = int_arb_priority;
	assign o_int_discard = (int_arb_priority == 4'h0);
	assign o_arb_participate = i_int_ack_cycle && !o_int_discard;
	assign o_autovector_response = i_int_ack_cycle && autovector_en && !o_int_discard
		&& autovector_mask_reg[i_int_ack_level];

	// ---------------------------------------------------------------
	// Checks.
	// ---------------------------------------------------------------
	sequence s_req_taken;
		i_bus_req && state_reg == scb_pkg::SCB_IDLE;
	endsequence

	sequence s_ack_next;
		##1 o_bus_ack;
	endsequence

	a_base_no_external: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(s_req_taken and base_hit) |-> ##1 (o_bus_ack && !o_run_external))
		else $error("module base access went external");

	a_invalid_no_block: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(s_req_taken and !base_valid and !base_hit) |-> s_ack_next ##0 o_run_external)
		else $error("block decoded before base was valid");

	a_masked_goes_out: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(s_req_taken and space_masked and !base_hit) |-> ##1 o_run_external)
		else $error("masked space was decoded internally");

	a_user_write_fault: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(s_req_taken and block_hit and i_shared_reg_sel and i_bus_wr
		and supervisor_lock_bit and !i_func_code[2]) |-> ##1 (o_bus_fault_resp && !o_periph_sel))
		else $error("user write under lock not faulted");

	a_unlocked_open: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(s_req_taken and block_hit and i_shared_reg_sel and !own_reg
		and !supervisor_lock_bit) |-> ##1 (!o_bus_fault_resp && o_periph_sel))
		else $error("unlocked shared register refused");

	a_cause_one_hot: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$fell(rst_seen_reg) |-> $onehot(reset_cause_reg))
		else $error("reset cause not exactly one flag");

	a_cause_write_ignored: assert property (@(posedge i_sys_clk)
		disable iff (i_rst || rst_seen_reg)
		(s_req_taken and i_bus_wr) |=> $stable(reset_cause_reg))
		else $error("reset cause changed by a write");

	a_arb_follows_show: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(show_cycle_select == 2'b01) |-> (!o_ext_req_accepted && !o_ext_arb_enable))
		else $error("external request seen with arbitration off");

	a_no_show_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(s_req_taken and !show_en) |=> (!o_show_drive && o_data_strobe_n && o_addr_strobe_n))
		else $error("internal access shown while show cycles off");

	a_zero_prio_silent: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(int_arb_priority == 4'h0) |-> (!o_autovector_response && !o_arb_participate))
		else $error("arbitration with zero priority");

	a_freeze_halt: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_timers_halt == (i_freeze && sys_config_reg[scb_pkg::CFG_FREEZE_TIMERS_POS]))
		else $error("timers halted without freeze");

	a_prio_after_reset: assert property (@(posedge i_sys_clk)
		(i_rst && !i_cause_instr) |=> (int_arb_priority == 4'hF))
		else $error("priority not F after reset");

endmodule // scb_sys_config

// ### sim/scb_core_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Processor core side of the register bus.
// ---------------------------------------------------------------
module scb_core_model (
	input wire logic i_sys_clk,
	input wire logic i_bus_ack,
	input wire logic [31:0] i_bus_rdata,
	input wire logic i_bus_fault_resp,
	input wire logic i_run_external,
	input wire logic i_periph_sel,
	output logic o_bus_req,
	output logic o_bus_wr,
	output logic [31:0] o_bus_addr,
	output logic [3:0] o_func_code,
	output logic [31:0] o_bus_wdata
);
	logic [34:0] rsp;

	// Idle bus at time zero so no request is seen before reset ends.
	initial begin
		o_bus_req = 1'b0;
		o_bus_wr = 1'b0;
		o_bus_addr = 32'h00000000;
		o_func_code = 4'h0;
		o_bus_wdata = 32'h00000000;
		rsp = 35'h000000000;
	end

	// One request pulse; the answer stands in the following cycle only.
	// Released lines carry inverted values so stale data never looks valid.
	task automatic access(input logic wr, input logic [31:0] addr, input logic [3:0] fc,
		input logic [31:0] wd, output logic ok);
		@(posedge i_sys_clk);
		#1;
		o_bus_req = 1'b1;
		o_bus_wr = wr;
		o_bus_addr = addr;
		o_func_code = fc;
		o_bus_wdata = wd;
		@(posedge i_sys_clk);
		#1;
		o_bus_req = 1'b0;
		o_bus_wr = ~wr;
		o_bus_addr = ~addr;
		o_func_code = ~fc;
		o_bus_wdata = ~wd;
		ok = i_bus_ack;
		rsp = {i_bus_fault_resp, i_run_external, i_periph_sel, i_bus_rdata};
	endtask
endmodule // scb_core_model

// ### sim/sys_config_base_decode_bench.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Self-checking bench of the configuration and base decode block.
// ---------------------------------------------------------------
module sys_config_base_decode_bench;
	localparam logic [31:0] BASE = 32'hFFFFF001;
	localparam logic [31:0] BLK = 32'hFFFFF000;
	localparam logic [31:0] MB = scb_pkg::MODULE_BASE_ADDR;
	localparam logic [3:0] FC7 = scb_pkg::FC_CPU_SPACE;
	localparam logic [3:0] FC5 = scb_pkg::FC_SUPER_DATA;
	typedef struct packed {
		logic [15:0] cfg;
		logic frz;
		logic pin_reset_flag;
		logic [2:0] lvl;
		logic [6:0] exp;
	} scb_row_t;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_shared_reg_sel = 1'b0;
	logic i_freeze = 1'b0;
	logic i_ext_bus_req = 1'b0;
	logic i_int_ack_cycle = 1'b0;
	logic [2:0] i_int_ack_level = 3'h0;
	logic i_cause_pin, i_cause_supply, i_cause_watchdog, i_cause_dfault, i_cause_instr;
	logic i_clock_lost, i_clock_loss_reset_enable, i_vco_enable;
	logic i_bus_req, i_bus_wr, o_bus_ack, o_bus_fault_resp, o_run_external, o_periph_sel;
	logic o_show_drive, o_addr_strobe_n, o_data_strobe_n, o_ext_arb_enable;
	logic o_ext_req_accepted, o_timers_halt, o_busmon_disable, o_arb_participate;
	logic o_int_discard, o_autovector_response, o_ref_missing_reset_req;
	logic [31:0] i_bus_addr, i_bus_wdata, o_bus_rdata, o_show_addr, o_show_data;
	logic [3:0] i_func_code, o_int_arb_priority;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	scb_row_t r;
	scb_row_t rows [8] = '{
		'{16'h400F, 1'h1, 1'h1, 3'h3, 7'h5C},
		'{16'h200F, 1'h1, 1'h1, 3'h3, 7'h3C},
		'{16'h610F, 1'h0, 1'h1, 3'h3, 7'h04},
		'{16'h020F, 1'h1, 1'h1, 3'h3, 7'h1C},
		'{16'h730F, 1'h1, 1'h1, 3'h3, 7'h7D},
		'{16'h100F, 1'h1, 1'h0, 3'h2, 7'h14},
		'{16'h1000, 1'h1, 1'h1, 3'h3, 7'h1A},
		'{16'h1081, 1'h0, 1'h1, 3'h3, 7'h1D}};
	logic [5:0] srcs [7] = '{6'h20, 6'h08, 6'h04, 6'h01, 6'h00, 6'h30, 6'h02};
	logic [7:0] causes [7] = '{8'h80, 8'h20, 8'h10, 8'h04, 8'h80, 8'h40, 8'h02};

	scb_sys_config dut_u (.i_sys_clk, .i_rst, .i_bus_req, .i_bus_wr, .i_bus_addr, .i_func_code,
		.i_bus_wdata, .i_shared_reg_sel, .i_freeze, .i_ext_bus_req, .i_int_ack_cycle,
		.i_int_ack_level, .i_cause_pin, .i_cause_supply, .i_cause_watchdog, .i_cause_dfault,
		.i_cause_instr, .i_clock_lost, .i_clock_loss_reset_enable, .i_vco_enable, .o_bus_ack,
		.o_bus_rdata, .o_bus_fault_resp, .o_run_external, .o_periph_sel, .o_show_drive,
		.o_addr_strobe_n, .o_data_strobe_n, .o_show_addr, .o_show_data, .o_ext_arb_enable,
		.o_ext_req_accepted, .o_timers_halt, .o_busmon_disable, .o_arb_participate,
		.o_int_arb_priority, .o_int_discard, .o_autovector_response, .o_ref_missing_reset_req);
	scb_core_model core_u (.i_sys_clk, .i_bus_ack(o_bus_ack), .i_bus_rdata(o_bus_rdata),
		.i_bus_fault_resp(o_bus_fault_resp), .i_run_external(o_run_external),
		.i_periph_sel(o_periph_sel), .o_bus_req(i_bus_req), .o_bus_wr(i_bus_wr),
		.o_bus_addr(i_bus_addr), .o_func_code(i_func_code), .o_bus_wdata(i_bus_wdata));

	// 200 MHz clock.
	initial begin
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	// The whole run needs well under a thousand cycles; this catches a hang.
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// ---------------------------------------------------------------
	// Shared tasks.
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One bus access; fep is the expected fault, external and peripheral flags.
	task automatic acc(input logic wr, input logic [31:0] a, input logic [3:0] fc,
		input logic [31:0] wd, input logic [2:0] fep, input logic [31:0] rd);
		logic ok;
		core_u.access(wr, a, fc, wd, ok);
		chk("ack", ok, 1'b1);
		chk("answer", core_u.rsp, {fep, rd});
	endtask

	// Reset for two cycles with the given sources: pin, supply, watchdog, fault, instr, loss.
	task automatic do_reset(input logic [5:0] src);
		{i_cause_pin, i_cause_supply, i_cause_watchdog, i_cause_dfault, i_cause_instr,
			i_clock_lost} = src;
		i_clock_loss_reset_enable = 1'b1;
		i_vco_enable = 1'b1;
		i_rst = 1'b1;
		repeat (2) @(posedge i_sys_clk);
		#1;
		i_rst = 1'b0;
		{i_cause_pin, i_cause_supply, i_cause_watchdog, i_cause_dfault, i_cause_instr,
			i_clock_lost} = 6'h00;
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence: reset, table rows, then the awkward cases.
	// ---------------------------------------------------------------
	initial begin
		do_reset(6'h30);
		chk("rst_out", {o_bus_ack, o_data_strobe_n, o_addr_strobe_n, o_int_arb_priority}, 7'h3F);
		acc(1'b0, MB, FC7, 32'h00000000, 3'h0, 32'h00000000);
		acc(1'b0, 32'h00000000, FC5, 32'h00000000, 3'h2, 32'h00000000);
		acc(1'b1, MB, FC7, 32'h12345C01, 3'h0, 32'h00000000);
		acc(1'b0, MB, FC7, 32'h00000000, 3'h0, 32'h12345001);
		acc(1'b0, 32'h12345000, FC5, 32'h00000000, 3'h0, 32'h0000000F);
		acc(1'b1, MB, FC7, BASE, 3'h0, 32'h00000000);
		acc(1'b1, BLK + 32'h00000006, FC5, 32'h000008FF, 3'h0, 32'h00000000);
		acc(1'b0, BLK + 32'h00000006, FC5, 32'h00000000, 3'h0, 32'h00000840);
		// Each row programs the configuration, reads it back and checks the levels.
		i_int_ack_cycle = 1'b1;
		foreach (rows[i]) begin
			r = rows[i];
			acc(1'b1, BLK, FC5, {16'h0000, r.cfg}, 3'h0, 32'h00000000);
			acc(1'b0, BLK, FC5, 32'h00000000, 3'h0, {16'h0000, r.cfg & scb_pkg::SYS_CONFIG_WMASK});
			chk("show", {o_show_drive, o_data_strobe_n, o_addr_strobe_n}, {|r.cfg[9:8], ~|r.cfg[9:8], 1'b1});
			if (|r.cfg[9:8]) chk("show_addr", o_show_addr, BLK);
			if (|r.cfg[9:8]) chk("show_data", o_show_data, {16'h0000, r.cfg & scb_pkg::SYS_CONFIG_WMASK});
			i_freeze = r.frz;
			i_ext_bus_req = r.pin_reset_flag;
			i_int_ack_level = r.lvl;
			#1;
			chk("levels", {o_timers_halt, o_busmon_disable, o_ext_arb_enable, o_ext_req_accepted, o_arb_participate, o_int_discard, o_autovector_response}, r.exp);
			chk("prio", o_int_arb_priority, r.cfg[3:0]);
		end
		// Outside an acknowledge cycle neither arbitration nor autovector may appear.
		i_int_ack_cycle = 1'b0;
		#1;
		chk("no_int_ack_cycle", {o_arb_participate, o_autovector_response}, 2'h0);
		// Lock set from the last row: user write to a shared register faults.
		i_shared_reg_sel = 1'b1;
		acc(1'b1, BLK + 32'h00000010, 4'h1, 32'h00000055, 3'h4, 32'h00000000);
		acc(1'b1, BLK + 32'h00000010, FC5, 32'h00000055, 3'h1, 32'h00000000);
		i_shared_reg_sel = 1'b0;
		acc(1'b1, BLK, FC5, 32'h0000000F, 3'h0, 32'h00000000);
		i_shared_reg_sel = 1'b1;
		acc(1'b1, BLK + 32'h00000010, 4'h1, 32'h00000055, 3'h1, 32'h00000000);
		i_shared_reg_sel = 1'b0;
		acc(1'b0, BLK, 4'h1, 32'h00000000, 3'h4, 32'h00000000);
		// Mask one space at a time; only that space goes external.
		for (int k = 0; k < 9; k++) begin
			acc(1'b1, MB, FC7, BASE | (32'h00000002 << k), 3'h0, 32'h00000000);
			acc(1'b0, BLK, (k == 8) ? 4'hC : 4'(k), 32'h00000000, 3'h2, 32'h00000000);
			if (k != 5) acc(1'b0, BLK, FC5, 32'h00000000, 3'h0, 32'h0000000F);
		end
		acc(1'b1, MB, FC7, BASE, 3'h0, 32'h00000000);
		for (int v = 0; v < 8; v++) begin
			@(posedge i_sys_clk);
			#1;
			{i_clock_lost, i_clock_loss_reset_enable, i_vco_enable} = 3'(v);
			#1;
			chk("loss_req", o_ref_missing_reset_req, v == 7);
		end
		// Every reset source; only the instruction reset keeps the configuration.
		foreach (srcs[j]) begin
			acc(1'b1, BLK + 32'h00000006, FC5, 32'h00000800, 3'h0, 32'h00000000);
			acc(1'b1, BLK, FC5, 32'h00000003, 3'h0, 32'h00000000);
			do_reset(srcs[j]);
			chk("prio_rst", o_int_arb_priority, (srcs[j] == 6'h02) ? 4'h3 : 4'hF);
			acc(1'b1, MB, FC7, BASE, 3'h0, 32'h00000000);
			acc(1'b0, BLK + 32'h00000006, FC5, 32'h00000000, 3'h0, {16'h0000, (srcs[j] == 6'h02) ? 8'h08 : 8'h00, causes[j]});
		end
		print_verdict();
	end
endmodule // sys_config_base_decode_bench
